// File: hw/ulmc_pkg.sv
package ulmc_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] ULMC_OFS_DATA = 3'h0;
	localparam logic [2:0] ULMC_OFS_IER = 3'h1;
	localparam logic [2:0] ULMC_OFS_EFR = 3'h2;
	localparam logic [2:0] ULMC_OFS_LCR = 3'h3;
	localparam logic [2:0] ULMC_OFS_MCR = 3'h4;
	localparam logic [2:0] ULMC_OFS_LSR = 3'h5;
	// line_format_reg fields
	localparam int ULMC_LCR_LEN = 0;
	localparam int ULMC_LCR_PEN = 3;
	localparam int ULMC_LCR_EVEN = 4;
	localparam int ULMC_LCR_FORCE = 5;
	localparam int ULMC_LCR_BRK = 6;
	localparam int ULMC_LCR_DLAB = 7;
	// modem_output_control fields
	localparam int ULMC_MCR_DTR = 0;
	localparam int ULMC_MCR_RTS = 1;
	localparam int ULMC_MCR_AUX1 = 2;
	localparam int ULMC_MCR_INTEN = 3;
	localparam int ULMC_MCR_LOOP = 4;
	localparam int ULMC_MCR_XANY = 5;
	localparam int ULMC_MCR_IR = 6;
	localparam int ULMC_MCR_PRESC = 7;
	// enhanced_feature_reg and interrupt_enable_reg fields
	localparam int ULMC_EFR_ENH = 4;
	localparam int ULMC_IER_RDA = 0;
	localparam int ULMC_IER_RLS = 2;
	// receive_line_status_reg fields
	localparam int ULMC_LSR_DR = 0;
	localparam int ULMC_LSR_OE = 1;
	localparam int ULMC_LSR_PE = 2;
	localparam int ULMC_LSR_FE = 3;
	// Reset values
	localparam logic [7:0] ULMC_LCR_RST = 8'h00;
	localparam logic [7:0] ULMC_MCR_RST = 8'h00;
	localparam logic [7:0] ULMC_IER_RST = 8'h00;
	localparam logic [7:0] ULMC_EFR_RST = 8'h00;
	localparam logic [7:0] ULMC_DLL_RST = 8'h01;
	localparam logic [7:0] ULMC_DLM_RST = 8'h00;
	// Counts: the first three in baud ticks, then the last-data-bit base and the clock divider counts
	localparam logic [3:0] ULMC_OVS_LAST = 4'hF;
	localparam logic [3:0] ULMC_MID_SAMPLE = 4'h7;
	localparam logic [3:0] ULMC_IR_PULSE = 4'h3;
	localparam logic [2:0] ULMC_LEN_BASE = 3'h4;
	localparam logic [1:0] ULMC_PRESC_DIV = 2'h3;
	localparam logic [1:0] ULMC_NO_DIV = 2'h1;

	typedef enum logic [2:0] {ULMC_TX_IDLE, ULMC_TX_START, ULMC_TX_DATA, ULMC_TX_PAR, ULMC_TX_STOP} ulmc_tx_st_t;
	typedef enum logic [2:0] {ULMC_RX_IDLE, ULMC_RX_START, ULMC_RX_DATA, ULMC_RX_PAR, ULMC_RX_STOP} ulmc_rx_st_t;

	typedef struct packed {
		logic [7:0] data;
		logic pe;
		logic fe;
	} ulmc_rx_entry_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ulmc_bus_t;
endpackage

// File: hw/ulmc_tick_div.sv
`timescale 1ns/1ns
module ulmc_tick_div import ulmc_pkg::*; #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [W-1:0] div,
	output logic pulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} ulmc_div_t;

	ulmc_div_t st_ff;
	ulmc_div_t nxt_st;
	logic [W-1:0] last;

	// A divisor of zero behaves as one rather than stalling
	assign last = (div == '0) ? '0 : div - W'(1);
	assign pulse = en && (st_ff.cnt >= last);

	always_comb begin
		nxt_st = st_ff;
		if (en) begin
			nxt_st.cnt = pulse ? '0 : st_ff.cnt + W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// File: hw/ulmc_parity.sv
`timescale 1ns/1ns
module ulmc_parity import ulmc_pkg::*; (
	input wire logic [7:0] data,
	input wire logic [1:0] len,
	input wire logic even_sel,
	input wire logic force_sel,
	output logic par
);
	logic [2:0] last;
	logic [7:0] mask;
	logic x;

	assign last = 3'(len) + ULMC_LEN_BASE;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			mask[i] = (3'(i) <= last);
		end
	end

	assign x = ^(data & mask);
	assign par = force_sel ? ~even_sel : (even_sel ? x : ~x);
endmodule

// File: hw/ulmc_top.sv
// Functional notes
// - Odd/even and forced parity apply only with parity enabled; otherwise none.
// - Parity type 0, no forcing: odd parity sent and checked.
// - Parity type 1, no forcing: even parity sent and checked.
// - Force set, type 0: parity bit fixed at one both ways.
// - Force set, type 1: parity bit fixed at zero both ways.
// - Break bit holds serial output low until software clears it, outside loopback and infrared mode.
// - Divisor-access bit steers data addresses to the baud divisor latches.
// - DTR bit one drives the active-low DTR pin low, zero high.
// - RTS bit one drives RTS pin low; software sets it for auto RTS.
// - No pin for aux output one; in loopback bit 2 gives ring state.
// - Interrupt pin three-stated when enable bit clear; aux two inverted in loopback.
// - Loopback bit selects internal local loopback; clearing restores normal.
// - Resume-any: any character resumes transmit; Xon/Xoff not stored under flow control.
// - Resume-any, infrared and prescaler bits act only with enhanced enable.
// - Infrared enable routes data through encoder/decoder; idle infrared output low.
// - Prescaler bit divides reference clock by four before the baud generator.
// - Line-status interrupt: overrun at once, errors when errored character at head.
// - Data-ready is one while any received character is held.
// - Character completing into a full FIFO sets overrun and is dropped.
// - Parity-error flag belongs to the character at the holding position.
// - Framing-error flag set when head character lacked a valid stop bit.
// - Listed control bits all reset to zero.
// - Parity enabled appends a parity bit and checks every received one.
// - Length field 00..11 gives 5..8 data bits, 5 by default.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
module ulmc_top import ulmc_pkg::*; #(
	parameter int RX_DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic rx_i,
	input wire logic ir_rx_i,
	input wire logic sw_flow_en,
	input wire logic [7:0] xon_char,
	input wire logic [7:0] xoff_char,
	output logic tx_o,
	output logic dtr_n,
	output logic rts_n,
	output logic irq_o,
	output logic irq_oe,
	output logic tx_resume,
	output logic loop_aux_output_one_n,
	output logic loop_aux_output_two_n
);
	localparam int AW = $clog2(RX_DEPTH);

	typedef struct packed {
		logic [7:0] line_format;
		logic [7:0] modem_output_control;
		logic [7:0] interrupt_enable_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] dll;
		logic [7:0] dlm;
		logic [7:0] rdata;
		logic [7:0] thr;
		logic thr_full;
		ulmc_tx_st_t tx_st;
		logic [3:0] tx_tick;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		ulmc_rx_st_t rx_st;
		logic [3:0] rx_tick;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_pbit;
		logic [3:0] ir_hold;
		ulmc_rx_entry_t [RX_DEPTH-1:0] fifo;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ovr;
		logic tx_pin;
		logic dtr_n;
		logic rts_n;
		logic irq;
		logic irq_oe;
		logic resume;
		logic aux1_n;
		logic aux2_n;
	} ulmc_state_t;

	ulmc_state_t st_ff;
	ulmc_state_t nxt_st;
	ulmc_bus_t bus;
	logic par_en;
	logic dlab;
	logic loop;
	logic enh;
	logic xon_any;
	logic ir_en;
	logic presc;
	logic [2:0] last_bit;
	logic pre_en;
	logic tick;
	logic tx_bit_end;
	logic tx_ser;
	logic line_bit;
	logic ir_pulse;
	logic ir_bit;
	logic rx_in;
	logic rx_sample;
	logic tx_par_calc;
	logic rx_par_exp;
	logic dr;
	logic pop;
	logic full;
	ulmc_rx_entry_t head;
	logic [7:0] receive_line_status;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign par_en = st_ff.line_format[ULMC_LCR_PEN];
	assign dlab = st_ff.line_format[ULMC_LCR_DLAB];
	assign loop = st_ff.modem_output_control[ULMC_MCR_LOOP];
	assign enh = st_ff.enhanced_feature_reg[ULMC_EFR_ENH];
	assign xon_any = enh & st_ff.modem_output_control[ULMC_MCR_XANY];
	assign ir_en = enh & st_ff.modem_output_control[ULMC_MCR_IR];
	assign presc = enh & st_ff.modem_output_control[ULMC_MCR_PRESC];
	assign last_bit = 3'(st_ff.line_format[1:0]) + ULMC_LEN_BASE;

	////////////////////////////////////////////////////////////////////////////////
	// Baud timing: prescaler then divisor, each a one-cycle enable

	ulmc_tick_div #(.W(3)) u_presc (
		.clk(clk),
		.rst(rst),
		.en(1'b1),
		.div(presc ? 3'(ULMC_PRESC_DIV) + 3'h1 : 3'(ULMC_NO_DIV)),
		.pulse(pre_en)
	);

	ulmc_tick_div #(.W(16)) u_baud (
		.clk(clk),
		.rst(rst),
		.en(pre_en),
		.div({st_ff.dlm, st_ff.dll}),
		.pulse(tick)
	);

	ulmc_parity u_tx_par (
		.data(st_ff.thr),
		.len(st_ff.line_format[1:0]),
		.even_sel(st_ff.line_format[ULMC_LCR_EVEN]),
		.force_sel(st_ff.line_format[ULMC_LCR_FORCE]),
		.par(tx_par_calc)
	);

	ulmc_parity u_rx_par (
		.data(st_ff.rx_sh),
		.len(st_ff.line_format[1:0]),
		.even_sel(st_ff.line_format[ULMC_LCR_EVEN]),
		.force_sel(st_ff.line_format[ULMC_LCR_FORCE]),
		.par(rx_par_exp)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Line path

	assign tx_bit_end = tick && (st_ff.tx_tick == ULMC_OVS_LAST);

	always_comb begin
		unique case (st_ff.tx_st)
			ULMC_TX_START: tx_ser = 1'b0;
			ULMC_TX_DATA: tx_ser = st_ff.tx_sh[0];
			ULMC_TX_PAR: tx_ser = st_ff.tx_par;
			default: tx_ser = 1'b1;
		endcase
	end

	assign line_bit = st_ff.line_format[ULMC_LCR_BRK] ? 1'b0 : tx_ser;
	// Encoder: short high pulse per zero bit, so an idle line stays low
	assign ir_pulse = ~line_bit && (st_ff.tx_tick < ULMC_IR_PULSE);
	// Decoder: a pulse marks a zero for one bit time after it
	assign ir_bit = ~(ir_rx_i | (st_ff.ir_hold != 4'h0));
	assign rx_in = loop ? line_bit : (ir_en ? ir_bit : rx_i);
	assign rx_sample = tick && (st_ff.rx_tick == ULMC_OVS_LAST);

	assign head = st_ff.fifo[st_ff.rp];
	assign dr = (st_ff.cnt != '0);
	assign pop = bus.rd && (bus.addr == ULMC_OFS_DATA) && !dlab && dr;
	assign full = (st_ff.cnt == (AW + 1)'(RX_DEPTH)) && !pop;
	assign receive_line_status = {4'h0, dr && head.fe, dr && head.pe, st_ff.ovr, dr};

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_st = st_ff;
		nxt_st.resume = 1'b0;
		nxt_st.rdata = 8'h00;
		// Register reads, data one cycle later
		if (bus.rd) begin
			unique case (bus.addr)
				ULMC_OFS_DATA: nxt_st.rdata = dlab ? st_ff.dll : (dr ? head.data : 8'h00);
				ULMC_OFS_IER: nxt_st.rdata = dlab ? st_ff.dlm : st_ff.interrupt_enable_reg;
				ULMC_OFS_EFR: nxt_st.rdata = st_ff.enhanced_feature_reg;
				ULMC_OFS_LCR: nxt_st.rdata = st_ff.line_format;
				ULMC_OFS_MCR: nxt_st.rdata = st_ff.modem_output_control;
				ULMC_OFS_LSR: nxt_st.rdata = receive_line_status;
				default: nxt_st.rdata = 8'h00;
			endcase
			if (bus.addr == ULMC_OFS_LSR) begin
				nxt_st.ovr = 1'b0;
			end
		end
		// Register writes; status register has no write path
		if (bus.wr) begin
			unique case (bus.addr)
				ULMC_OFS_DATA: begin
					if (dlab) begin
						nxt_st.dll = bus.wdata;
					end else begin
						nxt_st.thr = bus.wdata;
						nxt_st.thr_full = 1'b1;
					end
				end
				ULMC_OFS_IER: begin
					if (dlab) begin
						nxt_st.dlm = bus.wdata;
					end else begin
						nxt_st.interrupt_enable_reg = bus.wdata;
					end
				end
				ULMC_OFS_EFR: nxt_st.enhanced_feature_reg = bus.wdata;
				ULMC_OFS_LCR: nxt_st.line_format = bus.wdata;
				ULMC_OFS_MCR: nxt_st.modem_output_control = bus.wdata;
				default: ;
			endcase
		end

		// Transmitter; tick counter runs free so bits align to it
		if (tick) begin
			nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
		end
		unique case (st_ff.tx_st)
			ULMC_TX_IDLE, ULMC_TX_STOP: begin
				if (tx_bit_end) begin
					nxt_st.tx_st = ULMC_TX_IDLE;
					if (st_ff.thr_full) begin
						nxt_st.tx_sh = st_ff.thr;
						nxt_st.tx_par = tx_par_calc;
						nxt_st.thr_full = bus.wr && (bus.addr == ULMC_OFS_DATA) && !dlab;
						nxt_st.tx_st = ULMC_TX_START;
					end
				end
			end
			ULMC_TX_START: begin
				if (tx_bit_end) begin
					nxt_st.tx_bit = 3'h0;
					nxt_st.tx_st = ULMC_TX_DATA;
				end
			end
			ULMC_TX_DATA: begin
				if (tx_bit_end) begin
					nxt_st.tx_sh = {1'b0, st_ff.tx_sh[7:1]};
					nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
					if (st_ff.tx_bit == last_bit) begin
						nxt_st.tx_st = par_en ? ULMC_TX_PAR : ULMC_TX_STOP;
					end
				end
			end
			ULMC_TX_PAR: begin
				if (tx_bit_end) begin
					nxt_st.tx_st = ULMC_TX_STOP;
				end
			end
		endcase

		// Infrared receive pulse stretch
		if (ir_rx_i) begin
			nxt_st.ir_hold = ULMC_OVS_LAST;
		end else if (tick && (st_ff.ir_hold != 4'h0)) begin
			nxt_st.ir_hold = st_ff.ir_hold - 4'h1;
		end

		// Receiver
		if (tick) begin
			nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
		end
		unique case (st_ff.rx_st)
			ULMC_RX_IDLE: begin
				nxt_st.rx_tick = 4'h0;
				if (!rx_in) begin
					nxt_st.rx_st = ULMC_RX_START;
				end
			end
			ULMC_RX_START: begin
				if (tick && (st_ff.rx_tick == ULMC_MID_SAMPLE)) begin
					// Retime to mid-bit; a short glitch is dropped
					nxt_st.rx_tick = 4'h0;
					nxt_st.rx_bit = 3'h0;
					nxt_st.rx_sh = 8'h00;
					nxt_st.rx_st = rx_in ? ULMC_RX_IDLE : ULMC_RX_DATA;
				end
			end
			ULMC_RX_DATA: begin
				if (rx_sample) begin
					nxt_st.rx_sh[st_ff.rx_bit] = rx_in;
					nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
					if (st_ff.rx_bit == last_bit) begin
						nxt_st.rx_st = par_en ? ULMC_RX_PAR : ULMC_RX_STOP;
					end
				end
			end
			ULMC_RX_PAR: begin
				if (rx_sample) begin
					nxt_st.rx_pbit = rx_in;
					nxt_st.rx_st = ULMC_RX_STOP;
				end
			end
			ULMC_RX_STOP: begin
				if (rx_sample) begin
					nxt_st.rx_st = ULMC_RX_IDLE;
					nxt_st.resume = xon_any;
					if (!(sw_flow_en && (st_ff.rx_sh == xon_char || st_ff.rx_sh == xoff_char))) begin
						if (full) begin
							nxt_st.ovr = 1'b1;
						end else begin
							nxt_st.fifo[st_ff.wp].data = st_ff.rx_sh;
							nxt_st.fifo[st_ff.wp].pe = par_en && (st_ff.rx_pbit != rx_par_exp);
							nxt_st.fifo[st_ff.wp].fe = !rx_in;
							nxt_st.wp = st_ff.wp + AW'(1);
							nxt_st.cnt = st_ff.cnt + (AW + 1)'(1);
						end
					end
				end
			end
		endcase
		if (pop) begin
			nxt_st.rp = st_ff.rp + AW'(1);
			nxt_st.cnt = nxt_st.cnt - (AW + 1)'(1);
		end

		// Pins, all registered
		nxt_st.tx_pin = loop ? !ir_en : (ir_en ? ir_pulse : line_bit);
		nxt_st.dtr_n = loop ? 1'b1 : !st_ff.modem_output_control[ULMC_MCR_DTR];
		nxt_st.rts_n = loop ? 1'b1 : !st_ff.modem_output_control[ULMC_MCR_RTS];
		nxt_st.aux1_n = loop ? !st_ff.modem_output_control[ULMC_MCR_AUX1] : 1'b1;
		nxt_st.aux2_n = loop ? !st_ff.modem_output_control[ULMC_MCR_INTEN] : 1'b1;
		nxt_st.irq_oe = st_ff.modem_output_control[ULMC_MCR_INTEN];
		// Overrun flags at once; errors only once their character is at the head
		nxt_st.irq = (st_ff.interrupt_enable_reg[ULMC_IER_RLS] && (st_ff.ovr || (dr && (head.pe || head.fe))))
			|| (st_ff.interrupt_enable_reg[ULMC_IER_RDA] && dr);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.line_format <= ULMC_LCR_RST;
			st_ff.modem_output_control <= ULMC_MCR_RST;
			st_ff.interrupt_enable_reg <= ULMC_IER_RST;
			st_ff.enhanced_feature_reg <= ULMC_EFR_RST;
			st_ff.dll <= ULMC_DLL_RST;
			st_ff.dlm <= ULMC_DLM_RST;
			st_ff.tx_st <= ULMC_TX_IDLE;
			st_ff.rx_st <= ULMC_RX_IDLE;
			st_ff.tx_pin <= 1'b1;
			st_ff.dtr_n <= 1'b1;
			st_ff.rts_n <= 1'b1;
			st_ff.aux1_n <= 1'b1;
			st_ff.aux2_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign tx_o = st_ff.tx_pin;
	assign dtr_n = st_ff.dtr_n;
	assign rts_n = st_ff.rts_n;
	assign irq_o = st_ff.irq;
	assign irq_oe = st_ff.irq_oe;
	assign tx_resume = st_ff.resume;
	assign loop_aux_output_one_n = st_ff.aux1_n;
	assign loop_aux_output_two_n = st_ff.aux2_n;
endmodule

// File: testbench/ulmc_top_props.sv
`timescale 1ns/1ns
module ulmc_top_props import ulmc_pkg::*; #(
	parameter int RX_DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic tx_o,
	input wire logic dtr_n,
	input wire logic rts_n,
	input wire logic irq_oe,
	input wire logic tx_resume,
	input wire logic loop_aux_output_one_n,
	input wire logic loop_aux_output_two_n
);
	// Shadows of what software wrote, plus a one-edge delay for the pin lag
	logic [7:0] lcr_ff, mcr_ff, efr_ff, l_d_ff, m_d_ff, e_d_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lcr_ff <= 8'h00;
			mcr_ff <= 8'h00;
			efr_ff <= 8'h00;
			l_d_ff <= 8'h00;
			m_d_ff <= 8'h00;
			e_d_ff <= 8'h00;
		end else begin
			if (wr && addr == ULMC_OFS_LCR) lcr_ff <= wdata;
			if (wr && addr == ULMC_OFS_MCR) mcr_ff <= wdata;
			if (wr && addr == ULMC_OFS_EFR) efr_ff <= wdata;
			l_d_ff <= lcr_ff;
			m_d_ff <= mcr_ff;
			e_d_ff <= efr_ff;
		end
	end
	////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	dtr_pin_a: assert property (dtr_n == (m_d_ff[ULMC_MCR_LOOP] | ~m_d_ff[ULMC_MCR_DTR]))
		else $error("dtr pin wrong");
	rts_pin_a: assert property (rts_n == (m_d_ff[ULMC_MCR_LOOP] | ~m_d_ff[ULMC_MCR_RTS]))
		else $error("rts pin wrong");
	int_oe_a: assert property (irq_oe == m_d_ff[ULMC_MCR_INTEN])
		else $error("irq enable wrong");
	aux_one_a: assert property (loop_aux_output_one_n == ~(m_d_ff[ULMC_MCR_LOOP] & m_d_ff[ULMC_MCR_AUX1]))
		else $error("aux one wrong");
	aux_two_a: assert property (loop_aux_output_two_n == ~(m_d_ff[ULMC_MCR_LOOP] & m_d_ff[ULMC_MCR_INTEN]))
		else $error("aux two wrong");
	brk_low_a: assert property (l_d_ff[ULMC_LCR_BRK] && !m_d_ff[ULMC_MCR_LOOP]
		&& !(m_d_ff[ULMC_MCR_IR] && e_d_ff[ULMC_EFR_ENH]) |-> !tx_o)
		else $error("break not low");
	rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	lcr_read_a: assert property ($past(rd) && $past(addr) == ULMC_OFS_LCR |-> rdata == $past(lcr_ff))
		else $error("lcr readback wrong");
	resume_en_a: assert property (tx_resume |-> e_d_ff[ULMC_EFR_ENH] && m_d_ff[ULMC_MCR_XANY])
		else $error("resume while disabled");
	cover property (tx_resume);
	cover property (l_d_ff[ULMC_LCR_BRK] && !tx_o);
	cover property ($past(rd) && $past(addr) == ULMC_OFS_LSR && rdata[ULMC_LSR_OE]);
endmodule

bind ulmc_top ulmc_top_props #(.RX_DEPTH(RX_DEPTH)) i_ulmc_top_props (
	.clk(clk),
	.rst(rst),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.tx_o(tx_o),
	.dtr_n(dtr_n),
	.rts_n(rts_n),
	.irq_oe(irq_oe),
	.tx_resume(tx_resume),
	.loop_aux_output_one_n(loop_aux_output_one_n),
	.loop_aux_output_two_n(loop_aux_output_two_n)
);

// File: testbench/ulmc_remote_dev.sv
`timescale 1ns/1ns
module ulmc_remote_dev (
	input wire logic clk,
	input wire logic dev_tx,
	output logic dev_rx,
	output logic dev_ir
);
	int bit_clks = 16;
	// Infrared mode: data line stays idle, each zero bit is a short pulse
	logic ir_mode = 1'b0;
	initial dev_rx = 1'b1;
	initial dev_ir = 1'b0;
	task automatic put_bit(input logic v);
		dev_rx <= v | ir_mode;
		dev_ir <= ~v & ir_mode;
		repeat (3) @(posedge clk);
		dev_ir <= 1'b0;
		repeat (bit_clks - 3) @(posedge clk);
	endtask
	// Idle line is pulled high, so release means high
	task automatic send(input logic [7:0] d, input int nb, input logic use_par, input logic par, input logic stp);
		put_bit(1'b0);
		for (int k = 0; k < nb; k++) put_bit(d[k]);
		if (use_par) put_bit(par);
		put_bit(stp);
		put_bit(1'b1);
	endtask
	// Mid-bit sampling; bounded wait so a silent line cannot hang
	task automatic recv(input int nb, input logic use_par, output logic [7:0] d, output logic p, output logic s);
		int w;
		d = 8'h00;
		p = 1'b1;
		w = 0;
		while (dev_tx !== 1'b0 && w < 4000) begin
			@(posedge clk);
			w++;
		end
		repeat (bit_clks / 2) @(posedge clk);
		for (int k = 0; k < nb; k++) begin
			repeat (bit_clks) @(posedge clk);
			d[k] = dev_tx;
		end
		if (use_par) begin
			repeat (bit_clks) @(posedge clk);
			p = dev_tx;
		end
		repeat (bit_clks) @(posedge clk);
		s = dev_tx;
	endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top import ulmc_pkg::*; ;
	logic clk, rst, wr, rd, sw_flow_en, rx_line, ir_line, pe, gp, gs;
	logic tx_o, dtr_n, rts_n, irq_o, irq_oe, tx_resume, aux1_n, aux2_n;
	logic [2:0] addr;
	logic [7:0] wdata, xon_char, xoff_char, rdata, gd, l, dm, pins;
	int nb;
	int error_cnt = 0;
	int n_tests = 0;
	int res_cnt = 0;
	logic [7:0] mcr_v [5] = '{8'h03, 8'h08, 8'h1C, 8'h14, 8'h0C};
	logic [7:0] pin_v [5] = '{8'h23, 8'h3F, 8'h3C, 8'h39, 8'h3F};
	logic [7:0] lcr_v [5] = '{8'h00, 8'h0B, 8'h1B, 8'h2B, 8'h3B};
	assign pins = {2'h0, tx_o, dtr_n, rts_n, irq_oe, aux1_n, aux2_n};
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Small FIFO so overrun is reached in a few frames
	ulmc_top #(.RX_DEPTH(4)) i_ulmc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rx_i(rx_line), .ir_rx_i(ir_line), .sw_flow_en(sw_flow_en), .xon_char(xon_char),
		.xoff_char(xoff_char), .tx_o(tx_o), .dtr_n(dtr_n), .rts_n(rts_n), .irq_o(irq_o), .irq_oe(irq_oe),
		.tx_resume(tx_resume), .loop_aux_output_one_n(aux1_n), .loop_aux_output_two_n(aux2_n));
	ulmc_remote_dev i_ulmc_remote_dev (.clk(clk), .dev_tx(tx_o), .dev_rx(rx_line), .dev_ir(ir_line));
	always @(posedge clk) if (tx_resume === 1'b1) res_cnt++;
	////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	// Pins lag a write by two edges
	task automatic pin_chk(input logic [7:0] e);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(pins, e);
	endtask
	task final_report;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		$display("[FAIL] %0t timeout", $time);
		error_cnt++;
		final_report();
	end
	////////////////////////////////
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		sw_flow_en = 1'b0;
		xon_char = 8'h11;
		xoff_char = 8'h13;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(pins, 8'h3B);
		rd_chk(ULMC_OFS_MCR, 8'h00);
		wr_reg(ULMC_OFS_LSR, 8'hFF);
		rd_chk(ULMC_OFS_LSR, 8'h00);
		rd_chk(3'h6, 8'h00);
		wr_reg(ULMC_OFS_LCR, 8'h80);
		rd_chk(ULMC_OFS_DATA, 8'h01);
		wr_reg(ULMC_OFS_LCR, 8'h00);
		wr_reg(ULMC_OFS_IER, 8'h04);
		rd_chk(ULMC_OFS_DATA, 8'h00);
		wr_reg(ULMC_OFS_LCR, 8'h80);
		rd_chk(ULMC_OFS_IER, 8'h00);
		wr_reg(ULMC_OFS_LCR, 8'h00);
		rd_chk(ULMC_OFS_IER, 8'h04);
		for (int i = 0; i < 5; i++) begin
			wr_reg(ULMC_OFS_MCR, mcr_v[i]);
			pin_chk(pin_v[i]);
		end
		wr_reg(ULMC_OFS_MCR, 8'h00);
		wr_reg(ULMC_OFS_LCR, 8'h40);
		repeat (40) @(posedge clk);
		pin_chk(8'h1B);
		wr_reg(ULMC_OFS_LCR, 8'h00);
		pin_chk(8'h3B);
		wr_reg(ULMC_OFS_MCR, 8'h40);
		pin_chk(8'h3B);
		wr_reg(ULMC_OFS_EFR, 8'h10);
		pin_chk(8'h1B);
		wr_reg(ULMC_OFS_EFR, 8'h00);
		for (int i = 0; i < 5; i++) begin
			l = lcr_v[i];
			nb = 5 + int'(l[1:0]);
			dm = (l[3] ? 8'h34 : 8'h35) & (8'hFF >> (8 - nb));
			pe = l[5] ? ~l[4] : (l[4] ? ^dm : ~^dm);
			wr_reg(ULMC_OFS_LCR, l);
			wr_reg(ULMC_OFS_DATA, dm);
			i_ulmc_remote_dev.recv(nb, 1'b1, gd, gp, gs);
			chk(gd, dm);
			chk({6'h00, gp, gs}, {6'h00, l[3] ? pe : 1'b1, 1'b1});
			i_ulmc_remote_dev.send(dm, nb, l[3], pe, 1'b1);
			rd_chk(ULMC_OFS_LSR, 8'h01);
			rd_chk(ULMC_OFS_DATA, dm);
			i_ulmc_remote_dev.send(dm, nb, l[3], ~pe, l[3]);
			rd_chk(ULMC_OFS_LSR, l[3] ? 8'h05 : 8'h09);
			rd_chk(ULMC_OFS_DATA, dm);
		end
		// Prescaler ignored without enhanced enable, then divides by four
		wr_reg(ULMC_OFS_LCR, 8'h03);
		wr_reg(ULMC_OFS_MCR, 8'h80);
		wr_reg(ULMC_OFS_DATA, 8'hA5);
		i_ulmc_remote_dev.recv(8, 1'b0, gd, gp, gs);
		chk(gd, 8'hA5);
		wr_reg(ULMC_OFS_EFR, 8'h10);
		i_ulmc_remote_dev.bit_clks = 64;
		wr_reg(ULMC_OFS_DATA, 8'h5A);
		i_ulmc_remote_dev.recv(8, 1'b0, gd, gp, gs);
		chk(gd, 8'h5A);
		i_ulmc_remote_dev.bit_clks = 16;
		wr_reg(ULMC_OFS_EFR, 8'h00);
		// Divisor of two doubles the bit time
		wr_reg(ULMC_OFS_LCR, 8'h83);
		wr_reg(ULMC_OFS_DATA, 8'h02);
		wr_reg(ULMC_OFS_LCR, 8'h03);
		i_ulmc_remote_dev.bit_clks = 32;
		wr_reg(ULMC_OFS_DATA, 8'h3C);
		i_ulmc_remote_dev.recv(8, 1'b0, gd, gp, gs);
		chk(gd, 8'h3C);
		wr_reg(ULMC_OFS_LCR, 8'h83);
		wr_reg(ULMC_OFS_DATA, 8'h01);
		wr_reg(ULMC_OFS_LCR, 8'h03);
		i_ulmc_remote_dev.bit_clks = 16;
		wr_reg(ULMC_OFS_MCR, 8'h20);
		i_ulmc_remote_dev.send(8'h41, 8, 1'b0, 1'b0, 1'b1);
		chk(res_cnt[7:0], 8'h00);
		wr_reg(ULMC_OFS_EFR, 8'h10);
		i_ulmc_remote_dev.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
		chk(res_cnt[7:0], 8'h01);
		sw_flow_en <= 1'b1;
		i_ulmc_remote_dev.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
		chk(res_cnt[7:0], 8'h02);
		i_ulmc_remote_dev.send(8'h13, 8, 1'b0, 1'b0, 1'b1);
		chk(res_cnt[7:0], 8'h03);
		rd_chk(ULMC_OFS_DATA, 8'h41);
		rd_chk(ULMC_OFS_DATA, 8'h11);
		rd_chk(ULMC_OFS_LSR, 8'h00);
		sw_flow_en <= 1'b0;
		// Infrared receive: plain line idle, so only the decoder can deliver
		wr_reg(ULMC_OFS_MCR, 8'h40);
		i_ulmc_remote_dev.ir_mode = 1'b1;
		i_ulmc_remote_dev.send(8'h96, 8, 1'b0, 1'b0, 1'b1);
		i_ulmc_remote_dev.ir_mode = 1'b0;
		rd_chk(ULMC_OFS_DATA, 8'h96);
		wr_reg(ULMC_OFS_MCR, 8'h00);
		for (int i = 0; i < 5; i++) i_ulmc_remote_dev.send(8'hA0 + i[7:0], 8, 1'b0, 1'b0, 1'b1);
		@(negedge clk);
		chk({7'h00, irq_o}, 8'h01);
		rd_chk(ULMC_OFS_LSR, 8'h03);
		rd_chk(ULMC_OFS_LSR, 8'h01);
		for (int i = 0; i < 4; i++) rd_chk(ULMC_OFS_DATA, 8'hA0 + i[7:0]);
		rd_chk(ULMC_OFS_LSR, 8'h00);
		// Reset in mid-run clears what software set
		wr_reg(ULMC_OFS_LCR, 8'h7B);
		wr_reg(ULMC_OFS_MCR, 8'hEF);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(ULMC_OFS_LCR, 8'h00);
		rd_chk(ULMC_OFS_EFR, 8'h00);
		pin_chk(8'h3B);
		final_report();
	end
endmodule
